// ===== trb_bank_asserts.sv
// port assertions for the result register slice
`timescale 1ns/100ps
`default_nettype none
module trb_bank_asserts #(
  parameter int ADDR_WIDTH = 6
) (
  input wire logic                  i_clock,
  input wire logic                  i_rst_b,
  input wire logic                  i_instance_select_n,
  input wire logic [ADDR_WIDTH-1:0] i_addr,
  input wire logic [23:0]           i_wdata,
  input wire logic                  i_write,
  input wire logic                  i_read,
  input wire logic                  o_rdata_valid,
  input wire logic [15:0]           o_ref_overflow_limit,
  input wire logic [15:0]           o_ref_stop_mask
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire ws = i_write && !i_instance_select_n;
  chk_read_answer: assert property (i_read && !i_instance_select_n |=> o_rdata_valid)
    else $error("read not answered");
  chk_unsel_silent: assert property (i_instance_select_n |=> !o_rdata_valid)
    else $error("answer while deselected");
  chk_limit_low: assert property (ws && i_addr == 6'h07
    |=> o_ref_overflow_limit[7:0] == $past(i_wdata[7:0])) else $error("low limit lost");
  chk_limit_high: assert property (ws && i_addr == 6'h06
    |=> o_ref_overflow_limit[15:8] == $past(i_wdata[7:0])) else $error("high limit lost");
  chk_mask_high: assert property (ws && i_addr == 6'h08
    |=> o_ref_stop_mask[15:8] == $past(i_wdata[7:0])) else $error("high mask lost");
  chk_mask_low: assert property (ws && i_addr == 6'h09
    |=> o_ref_stop_mask[7:0] == $past(i_wdata[7:0])) else $error("low mask lost");
  // a write elsewhere, result offsets included, must leave the limit alone
  chk_limit_hold: assert property (!(ws && i_addr[5:1] == 5'h03)
    |=> $stable(o_ref_overflow_limit)) else $error("limit changed");
  chk_unsel_cfg: assert property (i_instance_select_n
    |=> $stable(o_ref_stop_mask)) else $error("mask changed while deselected");
  cov_limit_write: cover property (ws && i_addr == 6'h07);
  cov_unsel_read: cover property (i_read && i_instance_select_n);
  cov_unsel_write: cover property (i_write && i_instance_select_n);
endmodule
bind trb_result_register_bank trb_bank_asserts #(.ADDR_WIDTH(ADDR_WIDTH)) u_chk (.i_clock,
  .i_rst_b, .i_instance_select_n, .i_addr, .i_wdata, .i_write, .i_read, .o_rdata_valid,
  .o_ref_overflow_limit, .o_ref_stop_mask);
`default_nettype wire

// ===== trb_cfg_byte.sv
// one read-write configuration byte
`timescale 1ns/100ps
`default_nettype none
module trb_cfg_byte #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       i_clock,
  input  wire logic       i_rst_b,
  input  wire logic       i_write,
  input  wire logic [7:0] i_data,
  output logic      [7:0] o_value
);
  logic [7:0] value_q;

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      value_q <= RESET_VALUE;
    else if (i_write)
      value_q <= i_data;
  end

  assign o_value = value_q;
endmodule
`default_nettype wire

// ===== trb_params.svh
// offsets, field positions and reset values of the result register slice
`ifndef TRB_PARAMS_SVH
`define TRB_PARAMS_SVH
`define TRB_OFS_OVF_HIGH     6'h06
`define TRB_OFS_OVF_LOW      6'h07
`define TRB_OFS_MASK_HIGH    6'h08
`define TRB_OFS_MASK_LOW     6'h09
`define TRB_OFS_INTERVAL_1   6'h10
`define TRB_OFS_PERIOD_1     6'h11
`define TRB_OFS_INTERVAL_2   6'h12
`define TRB_OFS_PERIOD_2     6'h13
`define TRB_RST_OVF          8'hFF
`define TRB_RST_MASK         8'h00
`define TRB_RST_RESULT       24'h000000
`define TRB_RST_EXT          7'h00
`define TRB_BIT_PARITY       23
`define TRB_INTERVAL_MSB     22
`define TRB_COUNT_MSB        15
`define TRB_EXT_MSB          22
`define TRB_EXT_LSB          16
`endif

// ===== trb_pkg.sv
// types shared by the result register slice
package trb_pkg;
  typedef enum logic [1:0]
  {
    TRB_ACC_IDLE  = 2'b00,
    TRB_ACC_WRITE = 2'b01,
    TRB_ACC_READ  = 2'b11
  } trb_access_t;
endpackage

// ===== trb_result_register_bank.sv
// register slice of one converter: overflow limit, stop mask, two result pairs
//
// Local design decision: the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "trb_params.svh"
// Functional notes
// RULE1: offset 07h holds the low overflow-limit byte, read-write, reset FFh.
// RULE2: offset 06h holds the high overflow-limit byte, read-write, reset FFh.
// RULE3: offsets 08h and 09h hold the high and low stop-mask bytes, read-write, reset 00h.
// RULE4: offset 10h reads the first interval result, value in bits 22-0, reset zero.
// RULE5: an interval result is a 23-bit unsigned value in bits 22-0 with parity in bit 23.
// RULE6: offset 11h reads the first period tally, count in bits 15-0 and parity in bit 23.
// RULE7: bits 22-16 of each tally reset to zero and extend the count for averaging.
// RULE8: offset 12h reads the second interval result in the same format, reset zero.
// RULE9: offset 13h reads the second period tally in the same format, reset zero.
// RULE10: an access only reaches this instance while its active-low select is low.
// RULE11: writes to result registers are ignored; results load only on completion.
module trb_result_register_bank #(
  parameter int ADDR_WIDTH = 6
) (
  input  wire logic                  i_clock,
  input  wire logic                  i_rst_b,
  input  wire logic                  i_instance_select_n,
  input  wire logic [ADDR_WIDTH-1:0] i_addr,
  input  wire logic [23:0]           i_wdata,
  input  wire logic                  i_write,
  input  wire logic                  i_read,
  output logic      [23:0]           o_rdata,
  output logic                       o_rdata_valid,
  input  wire logic                  i_first_done,
  input  wire logic [22:0]           i_interval_value_first,
  input  wire logic [22:0]           i_period_tally_first,
  input  wire logic                  i_second_done,
  input  wire logic [22:0]           i_interval_value_second,
  input  wire logic [22:0]           i_period_tally_second,
  input  wire logic                  i_parity_odd,
  output logic      [15:0]           o_ref_overflow_limit,
  output logic      [15:0]           o_ref_stop_mask,
  output trb_pkg::trb_access_t       o_last_access
);
  // the offset decode is built for six address bits only
  if (ADDR_WIDTH != 6)
  begin : g_bad_addr_width
    $error("address width must be 6");
  end

  logic                  sel;
  logic                  wr_en;
  logic                  rd_en;
  logic [7:0]            ref_overflow_limit_high;
  logic [7:0]            ref_overflow_limit_low;
  logic [7:0]            ref_stop_mask_high;
  logic [7:0]            ref_stop_mask_low;
  logic [23:0]           load_value [4];
  logic [3:0]            load_en;
  logic [23:0]           slot_value [4];
  logic [23:0]           rdata_d;
  logic [23:0]           rdata_q;
  logic                  rvalid_q;
  trb_pkg::trb_access_t  access_q;

  // RULE10: select gates access
  assign sel   = !i_instance_select_n;
  assign wr_en = sel && i_write;
  assign rd_en = sel && i_read;

  // RULE2: overflow high byte
  trb_cfg_byte #(
    .RESET_VALUE (`TRB_RST_OVF)
  ) u_ovf_high (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_write (wr_en && (i_addr == `TRB_OFS_OVF_HIGH)),
    .i_data  (i_wdata[7:0]),
    .o_value (ref_overflow_limit_high)
  );

  // RULE1: overflow low byte
  trb_cfg_byte #(
    .RESET_VALUE (`TRB_RST_OVF)
  ) u_ovf_low (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_write (wr_en && (i_addr == `TRB_OFS_OVF_LOW)),
    .i_data  (i_wdata[7:0]),
    .o_value (ref_overflow_limit_low)
  );

  // RULE3: stop mask bytes
  trb_cfg_byte #(
    .RESET_VALUE (`TRB_RST_MASK)
  ) u_mask_high (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_write (wr_en && (i_addr == `TRB_OFS_MASK_HIGH)),
    .i_data  (i_wdata[7:0]),
    .o_value (ref_stop_mask_high)
  );

  trb_cfg_byte #(
    .RESET_VALUE (`TRB_RST_MASK)
  ) u_mask_low (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_write (wr_en && (i_addr == `TRB_OFS_MASK_LOW)),
    .i_data  (i_wdata[7:0]),
    .o_value (ref_stop_mask_low)
  );

  assign o_ref_overflow_limit = {ref_overflow_limit_high, ref_overflow_limit_low};
  assign o_ref_stop_mask      = {ref_stop_mask_high, ref_stop_mask_low};

  // RULE5: interval parity in bit 23
  assign load_value[0] = {^i_interval_value_first ^ i_parity_odd, i_interval_value_first};
  assign load_value[2] = {^i_interval_value_second ^ i_parity_odd, i_interval_value_second};
  // RULE7: tally extension bits 22-16
  assign load_value[1] = {^i_period_tally_first ^ i_parity_odd, i_period_tally_first};
  assign load_value[3] = {^i_period_tally_second ^ i_parity_odd, i_period_tally_second};

  // RULE11: completion drives loads
  assign load_en = {i_second_done, i_second_done, i_first_done, i_first_done};

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_slot
      trb_result_slot #(
        .WIDTH (24)
      ) u_slot (
        .i_clock (i_clock),
        .i_rst_b (i_rst_b),
        .i_load  (load_en[g]),
        .i_value (load_value[g]),
        .o_value (slot_value[g])
      );
    end
  endgenerate

  always_comb
  begin
    rdata_d = 24'h000000;
    case (i_addr)
      `TRB_OFS_OVF_HIGH:   rdata_d = {16'h0000, ref_overflow_limit_high};
      `TRB_OFS_OVF_LOW:    rdata_d = {16'h0000, ref_overflow_limit_low};
      `TRB_OFS_MASK_HIGH:  rdata_d = {16'h0000, ref_stop_mask_high};
      `TRB_OFS_MASK_LOW:   rdata_d = {16'h0000, ref_stop_mask_low};
      // RULE4: first interval read
      `TRB_OFS_INTERVAL_1: rdata_d = slot_value[0];
      // RULE6: first tally read
      `TRB_OFS_PERIOD_1:   rdata_d = slot_value[1];
      // RULE8: second interval read
      `TRB_OFS_INTERVAL_2: rdata_d = slot_value[2];
      // RULE9: second tally read
      `TRB_OFS_PERIOD_2:   rdata_d = slot_value[3];
      // unmapped offsets read as zero
      default:             rdata_d = 24'h000000;
    endcase
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
    begin
      rdata_q  <= 24'h000000;
      rvalid_q <= 1'b0;
    end
    else
    begin
      rdata_q  <= rd_en ? rdata_d : 24'h000000;
      rvalid_q <= rd_en;
    end
  end

  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      access_q <= trb_pkg::TRB_ACC_IDLE;
    else if (wr_en)
      access_q <= trb_pkg::TRB_ACC_WRITE;
    else if (rd_en)
      access_q <= trb_pkg::TRB_ACC_READ;
  end

  assign o_rdata       = rdata_q;
  assign o_rdata_valid = rvalid_q;
  assign o_last_access = access_q;
endmodule
`default_nettype wire

// ===== trb_result_register_bank_tb_top.sv
// bench for the result register slice
`timescale 1ns/100ps
`default_nettype none
module trb_result_register_bank_tb_top;
  logic        i_clock = 1'h0, i_rst_b = 1'h0, i_instance_select_n = 1'h1;
  logic        i_write = 1'h0, i_read = 1'h0, i_parity_odd = 1'h0;
  logic        i_first_done = 1'h0, i_second_done = 1'h0, o_rdata_valid;
  logic [5:0]  i_addr = 6'h00;
  logic [23:0] i_wdata = 24'h000000, o_rdata, sh [0:31];
  logic [22:0] v1 = 23'h0, t1 = 23'h0, v2 = 23'h0, t2 = 23'h0;
  logic [15:0] o_ref_overflow_limit, o_ref_stop_mask;
  int          fails = 0, num_checks = 0;
  trb_pkg::trb_access_t la;
  trb_result_register_bank u_dut (.i_clock, .i_rst_b, .i_instance_select_n, .i_addr,
    .i_wdata, .i_write, .i_read, .o_rdata, .o_rdata_valid, .i_first_done,
    .i_interval_value_first(v1), .i_period_tally_first(t1), .i_second_done,
    .i_interval_value_second(v2), .i_period_tally_second(t2), .i_parity_odd,
    .o_ref_overflow_limit, .o_ref_stop_mask, .o_last_access(la));
  initial
  begin
    forever #2.5 i_clock = ~i_clock;
  end
  task automatic chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d, input logic s);
    @(posedge i_clock);
    i_write <= 1'h1;
    i_addr <= a;
    i_wdata <= {16'hFFFF, d};
    i_instance_select_n <= s;
    @(posedge i_clock);
    i_write <= 1'h0;
    i_instance_select_n <= 1'h0;
    if (!s && a inside {[6'h06:6'h09]})
      sh[a] = {16'h0000, d};
    #1 if (!s) chk({30'h0, la}, {30'h0, trb_pkg::TRB_ACC_WRITE});
  endtask
  task automatic rd(input logic [5:0] a, input logic s);
    @(posedge i_clock);
    i_read <= 1'h1;
    i_addr <= a;
    i_instance_select_n <= s;
    @(posedge i_clock);
    i_read <= 1'h0;
    i_instance_select_n <= 1'h0;
    #1 chk({31'h0, o_rdata_valid}, {31'h0, !s});
    chk({8'h00, o_rdata}, s ? 32'h0 : {8'h00, sh[a]});
    if (!s) chk({30'h0, la}, {30'h0, trb_pkg::TRB_ACC_READ});
  endtask
  // the load ports change after the pulse, so a slot that keeps loading shows up
  task automatic ld(input logic k, input logic [22:0] v, t, input logic p);
    @(posedge i_clock);
    {v1, t1, v2, t2} <= {v, t, v, t};
    i_parity_odd <= p;
    i_first_done <= !k;
    i_second_done <= k;
    @(posedge i_clock);
    {v1, t1, v2, t2} <= ~{v, t, v, t};
    {i_first_done, i_second_done} <= 2'h0;
    sh[16 + 2 * k] = {^v ^ p, v};
    sh[17 + 2 * k] = {^t ^ p, t};
  endtask
  task automatic sweep(input string n);
    for (int a = 6; a < 21; a++)
      rd(6'(a), 1'h0);
    $display("test %s done", n);
  endtask
  task automatic rst;
    i_rst_b <= 1'h0;
    repeat (6) @(posedge i_clock);
    i_rst_b <= 1'h1;
    foreach (sh[i]) sh[i] = 24'h000000;
    sh[6] = 24'h0000FF;
    sh[7] = 24'h0000FF;
  endtask
  task automatic close_out;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    rst;
    sweep("reset");
    chk({o_ref_overflow_limit, o_ref_stop_mask}, 32'hFFFF0000);
    wr(6'h07, 8'hA5, 1'h0);
    wr(6'h06, 8'h3C, 1'h0);
    wr(6'h08, 8'h81, 1'h0);
    wr(6'h09, 8'h7E, 1'h0);
    #1 chk({o_ref_overflow_limit, o_ref_stop_mask}, 32'h3CA5817E);
    for (int a = 16; a < 20; a++)
      wr(6'(a), 8'hC3, 1'h0);
    wr(6'h0A, 8'h5A, 1'h0);
    wr(6'h07, 8'h00, 1'h1);
    rd(6'h07, 1'h1);
    sweep("write");
    ld(1'h0, 23'h5A5A5A, 23'h7F1234, 1'h0);
    ld(1'h1, 23'h000001, 23'h00FFFF, 1'h1);
    sweep("load");
    rst;
    sweep("second reset");
    close_out;
  end
endmodule
`default_nettype wire

// ===== trb_result_slot.sv
// one result register with load-only update
`timescale 1ns/100ps
`default_nettype none
`include "trb_params.svh"
module trb_result_slot #(
  parameter int WIDTH = 24
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_b,
  input  wire logic             i_load,
  input  wire logic [WIDTH-1:0] i_value,
  output logic      [WIDTH-1:0] o_value
);
  // reset constant and parity position assume a 24-bit register
  if (WIDTH != 24)
  begin : g_bad_width
    $error("result slot width must be 24");
  end

  logic [WIDTH-1:0] value_q;

  // RULE11: load on completion
  always_ff @(posedge i_clock)
  begin
    if (!i_rst_b)
      value_q <= `TRB_RST_RESULT;
    else if (i_load)
      value_q <= i_value;
  end

  assign o_value = value_q;
endmodule
`default_nettype wire
